//--- rtl/port_vc_aer_consts.vh
// constants for the per-port channel, serial number and error reporting register bank
`ifndef PORT_VC_AER_CONSTS_VH
`define PORT_VC_AER_CONSTS_VH

// configuration functions that carry a copy of the bank
`define FUNC_FIRST 4'h2
`define FUNC_LAST 4'hc
`define FUNC_COUNT 11

// byte offsets
`define OFS_CH0_CAP 12'h120
`define OFS_CH0_CTL 12'h124
`define OFS_CH0_STATE 12'h12a
`define OFS_CH1_CAP 12'h12c
`define OFS_CH1_CTL 12'h130
`define OFS_CH1_STATE 12'h136
`define OFS_SER_HDR 12'h140
`define OFS_SER_LOW 12'h144
`define OFS_SER_HIGH 12'h148
`define OFS_ERR_HDR 12'h150
`define OFS_UNC_STS 12'h154
`define OFS_UNC_MSK 12'h158
`define OFS_UNC_SEV 12'h15c
`define OFS_COR_STS 12'h160
`define OFS_COR_MSK 12'h164
`define OFS_ERR_CTL 12'h168
`define OFS_LOG0 12'h16c
`define OFS_LOG1 12'h170
`define OFS_LOG2 12'h174
`define OFS_LOG3 12'h178
`define OFS_ROOT_CMD 12'h17c
`define OFS_ROOT_STS 12'h180
`define OFS_REQ_IDS 12'h184

// fixed read values
`define CH_CAP_VALUE 32'h00000001
`define CH_STATE_RESET 16'h0002
`define SER_HDR_VALUE 32'h15010003
`define ERR_HDR_VALUE 32'h19010001
`define SER_LOW_VALUE 32'h00000000
`define SER_HIGH_VALUE 32'h00000000
`define ERR_CTL_VALUE 32'h00000000
`define ROOT_VECTOR_VALUE 5'h00

// channel 0 control
`define CH0_CTL_FIXED 32'h80000001
`define CH0_CTL_RW 32'h000e00fe
`define CH0_CTL_RESET 32'h000000fe
// channel 1 control
`define CH1_CTL_RW 32'h870e00fe
`define CH1_CTL_RESET 32'h00000000
`define CH1_ENABLE_BIT 31

// uncorrectable group
`define UNC_DEFINED 32'h003ff030
`define UNC_SW 32'h00355010
`define UNC_STS_RESET 32'h00000000
`define UNC_MSK_RESET 32'h00000000
`define UNC_SEV_RESET 32'h00062030

// correctable group
`define COR_DEFINED 32'h000031c1
`define COR_STS_RESET 32'h00000000
`define COR_MSK_RESET 32'h00002000

// root error command and status
`define ROOT_CMD_BITS 3'h7
`define ROOT_STS_BITS 7'h7f
`define ROOT_CMD_COR 0
`define ROOT_CMD_NONFATAL 1
`define ROOT_CMD_FATAL 2
`define ROOT_VECTOR_LSB 27

`endif

//--- rtl/pcie_port_vc_aer_regs.v
// per-port channel resource, serial number and error reporting configuration registers
`default_nettype none
`include "port_vc_aer_consts.vh"

// Notes on behaviour
// - separate bank copy for functions 2 to 12
// - channel 0 capability fixed, arbitration field 0x1
// - channel 0 map and arbitration select writable
// - channel 0 load/id zero, enable fixed one
// - channel 0 state: table zero, pending one
// - channel 1 capability same as channel 0
// - channel 1 control resets zero, mostly writable
// - channel 1 state: table zero, pending one
// - serial header id 3, version 1, next 0x150
// - serial number two read-only zero words
// - error header id 1, version 1, next 0x190
// - uncorrectable flags, five positions read-only
// - uncorrectable mask mirrors flags, resets zero
// - severity resets fatal for 4,5,13,17,18
// - correctable flags at six positions, reset zero
// - correctable mask, only advisory bit resets one
// - capability control all read-only zero
// - four read-only header log words, reset zero
// - root status flags plus fixed vector field
// - requester identifiers read-only, reset zero
module pcie_port_vc_aer_regs (
    // clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // configuration access
    input wire [3:0] cfg_func_in,
    input wire [11:0] cfg_addr_in,
    input wire cfg_wr_in,
    input wire cfg_rd_in,
    input wire [3:0] cfg_be_in,
    input wire [31:0] cfg_wdata_in,
    output wire [31:0] cfg_rdata_out,
    output wire cfg_rvalid_out,
    // error events from the link logic
    input wire evt_valid_in,
    input wire [3:0] evt_func_in,
    input wire [31:0] unc_evt_in,
    input wire [31:0] cor_evt_in,
    input wire [6:0] root_evt_in,
    input wire [15:0] evt_src_id_in,
    input wire hdr_capture_in,
    input wire [127:0] hdr_in,
    // per-function results, bit 0 is function 2
    output wire [`FUNC_COUNT-1:0] ch1_enable_out,
    output wire [`FUNC_COUNT-1:0] report_cor_out,
    output wire [`FUNC_COUNT-1:0] report_nonfatal_out,
    output wire [`FUNC_COUNT-1:0] report_fatal_out
);

    function [31:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // merge written data into the writable positions only
    function [31:0] rw_merge;
        input [31:0] old;
        input [31:0] data;
        input [31:0] lanes;
        input [31:0] msk;
        begin
            rw_merge = (old & ~(lanes & msk)) | (data & lanes & msk);
        end
    endfunction

    // write-one-to-clear with hardware set taking priority
    function [31:0] w1c_merge;
        input [31:0] old;
        input [31:0] data;
        input [31:0] lanes;
        input [31:0] msk;
        input [31:0] setv;
        begin
            w1c_merge = (old & ~(data & lanes & msk)) | setv;
        end
    endfunction

    function hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            hit = (addr[11:2] == ofs[11:2]);
        end
    endfunction

    wire [31:0] lanes = lane_mask(cfg_be_in);
    wire [`FUNC_COUNT*32-1:0] rd_vec;
    wire func_ok = (cfg_func_in >= `FUNC_FIRST) && (cfg_func_in <= `FUNC_LAST);
    wire [3:0] func_idx = cfg_func_in - `FUNC_FIRST;

    reg [31:0] rdata_ff;
    reg rvalid_ff;
    reg [31:0] nxt_rdata;

    genvar gi;
    generate
        for (gi = 0; gi < `FUNC_COUNT; gi = gi + 1) begin : g_func
            localparam [31:0] FUNC_NUM = gi + 2;
            wire [3:0] my_func = FUNC_NUM[3:0];
            wire wr_hit = cfg_wr_in && (cfg_func_in == my_func);
            wire ev_hit = evt_valid_in && (evt_func_in == my_func);

            reg [31:0] ch0_ctl_ff;
            reg [31:0] ch1_ctl_ff;
            reg [31:0] unc_sts_ff;
            reg [31:0] unc_msk_ff;
            reg [31:0] unc_sev_ff;
            reg [31:0] cor_sts_ff;
            reg [31:0] cor_msk_ff;
            reg [2:0] root_cmd_ff;
            reg [6:0] root_sts_ff;
            reg [15:0] cor_req_ff;
            reg [15:0] unc_req_ff;
            reg [127:0] log_ff;
            reg ch1_en_ff;
            reg rep_cor_ff;
            reg rep_nf_ff;
            reg rep_fat_ff;
            reg [31:0] rd;

            wire [31:0] unc_set = ev_hit ? (unc_evt_in & `UNC_DEFINED) : 32'h00000000;
            wire [31:0] cor_set = ev_hit ? (cor_evt_in & `COR_DEFINED) : 32'h00000000;
            wire [6:0] root_set = ev_hit ? (root_evt_in & `ROOT_STS_BITS) : 7'h00;
            wire [31:0] unc_open = unc_sts_ff & ~unc_msk_ff;

            always @(posedge ref_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    ch0_ctl_ff <= `CH0_CTL_RESET;
                    ch1_ctl_ff <= `CH1_CTL_RESET;
                    unc_sts_ff <= `UNC_STS_RESET;
                    unc_msk_ff <= `UNC_MSK_RESET;
                    unc_sev_ff <= `UNC_SEV_RESET;
                    cor_sts_ff <= `COR_STS_RESET;
                    cor_msk_ff <= `COR_MSK_RESET;
                    root_cmd_ff <= 3'h0;
                    root_sts_ff <= 7'h00;
                    cor_req_ff <= 16'h0000;
                    unc_req_ff <= 16'h0000;
                    log_ff <= 128'h0;
                    ch1_en_ff <= 1'b0;
                    rep_cor_ff <= 1'b0;
                    rep_nf_ff <= 1'b0;
                    rep_fat_ff <= 1'b0;
                end else begin
                    // only the writable positions take data
                    if (wr_hit && hit(cfg_addr_in, `OFS_CH0_CTL)) begin
                        ch0_ctl_ff <= rw_merge(ch0_ctl_ff, cfg_wdata_in, lanes,
                            `CH0_CTL_RW);
                    end
                    if (wr_hit && hit(cfg_addr_in, `OFS_CH1_CTL)) begin
                        ch1_ctl_ff <= rw_merge(ch1_ctl_ff, cfg_wdata_in, lanes,
                            `CH1_CTL_RW);
                    end
                    if (wr_hit && hit(cfg_addr_in, `OFS_UNC_MSK)) begin
                        unc_msk_ff <= rw_merge(unc_msk_ff, cfg_wdata_in, lanes,
                            `UNC_SW);
                    end
                    if (wr_hit && hit(cfg_addr_in, `OFS_UNC_SEV)) begin
                        unc_sev_ff <= rw_merge(unc_sev_ff, cfg_wdata_in, lanes,
                            `UNC_SW);
                    end
                    if (wr_hit && hit(cfg_addr_in, `OFS_COR_MSK)) begin
                        cor_msk_ff <= rw_merge(cor_msk_ff, cfg_wdata_in, lanes,
                            `COR_DEFINED);
                    end
                    if (wr_hit && hit(cfg_addr_in, `OFS_ROOT_CMD) && cfg_be_in[0]) begin
                        root_cmd_ff <= cfg_wdata_in[2:0] & `ROOT_CMD_BITS;
                    end
                    // status flags: set wins over a clear in the same cycle
                    if (wr_hit && hit(cfg_addr_in, `OFS_UNC_STS)) begin
                        unc_sts_ff <= w1c_merge(unc_sts_ff, cfg_wdata_in, lanes,
                            `UNC_SW, unc_set);
                    end else begin
                        unc_sts_ff <= unc_sts_ff | unc_set;
                    end
                    if (wr_hit && hit(cfg_addr_in, `OFS_COR_STS)) begin
                        cor_sts_ff <= w1c_merge(cor_sts_ff, cfg_wdata_in, lanes,
                            `COR_DEFINED, cor_set);
                    end else begin
                        cor_sts_ff <= cor_sts_ff | cor_set;
                    end
                    if (wr_hit && hit(cfg_addr_in, `OFS_ROOT_STS) && cfg_be_in[0]) begin
                        root_sts_ff <= (root_sts_ff & ~cfg_wdata_in[6:0])
                            | root_set;
                    end else begin
                        root_sts_ff <= root_sts_ff | root_set;
                    end
                    // requester identifiers follow the event class
                    if (|cor_set) begin
                        cor_req_ff <= evt_src_id_in;
                    end
                    if (|unc_set) begin
                        unc_req_ff <= evt_src_id_in;
                    end
                    if (ev_hit && hdr_capture_in) begin
                        log_ff <= hdr_in;
                    end
                    ch1_en_ff <= ch1_ctl_ff[`CH1_ENABLE_BIT];
                    rep_cor_ff <= root_cmd_ff[`ROOT_CMD_COR] && |(cor_sts_ff & ~cor_msk_ff);
                    rep_nf_ff <= root_cmd_ff[`ROOT_CMD_NONFATAL] && |(unc_open & ~unc_sev_ff);
                    rep_fat_ff <= root_cmd_ff[`ROOT_CMD_FATAL] && |(unc_open & unc_sev_ff);
                end
            end

            // read view; 16-bit registers sit in the upper half of their word
            always @* begin
                rd = 32'h00000000;
                if (hit(cfg_addr_in, `OFS_CH0_CAP) || hit(cfg_addr_in, `OFS_CH1_CAP)) begin
                    rd = `CH_CAP_VALUE;
                end else if (hit(cfg_addr_in, `OFS_CH0_CTL)) begin
                    rd = (ch0_ctl_ff & `CH0_CTL_RW) | `CH0_CTL_FIXED;
                end else if (hit(cfg_addr_in, `OFS_CH0_STATE)
                        || hit(cfg_addr_in, `OFS_CH1_STATE)) begin
                    rd = {`CH_STATE_RESET, 16'h0000};
                end else if (hit(cfg_addr_in, `OFS_CH1_CTL)) begin
                    rd = ch1_ctl_ff & `CH1_CTL_RW;
                end else if (hit(cfg_addr_in, `OFS_SER_HDR)) begin
                    rd = `SER_HDR_VALUE;
                end else if (hit(cfg_addr_in, `OFS_SER_LOW)) begin
                    rd = `SER_LOW_VALUE;
                end else if (hit(cfg_addr_in, `OFS_SER_HIGH)) begin
                    rd = `SER_HIGH_VALUE;
                end else if (hit(cfg_addr_in, `OFS_ERR_HDR)) begin
                    rd = `ERR_HDR_VALUE;
                end else if (hit(cfg_addr_in, `OFS_UNC_STS)) begin
                    rd = unc_sts_ff & `UNC_DEFINED;
                end else if (hit(cfg_addr_in, `OFS_UNC_MSK)) begin
                    rd = unc_msk_ff & `UNC_DEFINED;
                end else if (hit(cfg_addr_in, `OFS_UNC_SEV)) begin
                    rd = unc_sev_ff & `UNC_DEFINED;
                end else if (hit(cfg_addr_in, `OFS_COR_STS)) begin
                    rd = cor_sts_ff & `COR_DEFINED;
                end else if (hit(cfg_addr_in, `OFS_COR_MSK)) begin
                    rd = cor_msk_ff & `COR_DEFINED;
                end else if (hit(cfg_addr_in, `OFS_ERR_CTL)) begin
                    rd = `ERR_CTL_VALUE;
                end else if (hit(cfg_addr_in, `OFS_LOG0)) begin
                    rd = log_ff[31:0];
                end else if (hit(cfg_addr_in, `OFS_LOG1)) begin
                    rd = log_ff[63:32];
                end else if (hit(cfg_addr_in, `OFS_LOG2)) begin
                    rd = log_ff[95:64];
                end else if (hit(cfg_addr_in, `OFS_LOG3)) begin
                    rd = log_ff[127:96];
                end else if (hit(cfg_addr_in, `OFS_ROOT_CMD)) begin
                    rd = {29'h0, root_cmd_ff};
                end else if (hit(cfg_addr_in, `OFS_ROOT_STS)) begin
                    rd = {`ROOT_VECTOR_VALUE, 20'h00000, root_sts_ff};
                end else if (hit(cfg_addr_in, `OFS_REQ_IDS)) begin
                    rd = {unc_req_ff, cor_req_ff};
                end
            end

            assign rd_vec[gi*32 +: 32] = rd;
            assign ch1_enable_out[gi] = ch1_en_ff;
            assign report_cor_out[gi] = rep_cor_ff;
            assign report_nonfatal_out[gi] = rep_nf_ff;
            assign report_fatal_out[gi] = rep_fat_ff;
        end
    endgenerate

    // unsupported functions read as zero
    always @* begin
        nxt_rdata = rdata_ff;
        if (cfg_rd_in) begin
            nxt_rdata = func_ok ? rd_vec[func_idx*32 +: 32] : 32'h00000000;
        end
    end

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_ff <= 32'h00000000;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= cfg_rd_in;
        end
    end

    assign cfg_rdata_out = rdata_ff;
    assign cfg_rvalid_out = rvalid_ff;

endmodule // pcie_port_vc_aer_regs
`default_nettype wire

//--- verification/regs_chk_sva.sv
// assertions on the port register bank
`default_nettype none
module regs_chk (
    // clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // configuration access
    input wire [3:0] cfg_func_in,
    input wire [11:0] cfg_addr_in,
    input wire cfg_rd_in,
    input wire [31:0] cfg_rdata_out,
    input wire cfg_rvalid_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    wire rd_ok = cfg_rd_in && cfg_func_in >= 4'h2 && cfg_func_in <= 4'hc;
    wire [9:0] dw = cfg_addr_in[11:2];
    a_read_answer: assert property (cfg_rd_in |=> cfg_rvalid_out)
        else $error("read unanswered");
    a_no_stray: assert property (cfg_rvalid_out |-> $past(cfg_rd_in))
        else $error("stray read valid");
    a_data_holds: assert property (!cfg_rvalid_out |-> $stable(cfg_rdata_out))
        else $error("read data moved");
    a_cap_words: assert property (rd_ok
        && (dw == 10'h48 || dw == 10'h4b) |=> cfg_rdata_out == 32'h1)
        else $error("capability word");
    a_ch0_fixed: assert property (rd_ok && dw == 10'h49 |=>
        cfg_rdata_out[31] && cfg_rdata_out[0]
        && cfg_rdata_out[26:24] == 3'h0 && !cfg_rdata_out[16])
        else $error("channel 0 fixed bits");
    a_state_words: assert property (rd_ok
        && (dw == 10'h4a || dw == 10'h4d) |=> cfg_rdata_out == 32'h00020000)
        else $error("state word");
    a_serial_hdr: assert property (rd_ok && dw == 10'h50
        |=> cfg_rdata_out == 32'h15010003) else $error("serial header");
    a_error_hdr: assert property (rd_ok && dw == 10'h54
        |=> cfg_rdata_out == 32'h19010001) else $error("error header");
    a_zero_words: assert property (rd_ok
        && (dw == 10'h51 || dw == 10'h52 || dw == 10'h5a) |=> cfg_rdata_out == 32'h0)
        else $error("zero word");
    a_root_vector: assert property (rd_ok && dw == 10'h60
        |=> cfg_rdata_out[31:27] == 5'h0) else $error("vector field");
endmodule // regs_chk
bind pcie_port_vc_aer_regs regs_chk u_chk (.ref_clk_in, .rstn_in, .cfg_func_in, .cfg_addr_in,
    .cfg_rd_in, .cfg_rdata_out, .cfg_rvalid_out);
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the port register bank
`default_nettype none
`include "port_vc_aer_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [3:0] cfg_func_in = 4'h0;
    logic [11:0] cfg_addr_in = 12'h0;
    logic cfg_wr_in = 1'b0;
    logic cfg_rd_in = 1'b0;
    logic [3:0] cfg_be_in = 4'hf;
    logic [31:0] cfg_wdata_in = 32'h0;
    logic evt_valid_in = 1'b0;
    logic [3:0] evt_func_in = 4'h0;
    logic [31:0] unc_evt_in = 32'h0;
    logic [31:0] cor_evt_in = 32'h0;
    logic [6:0] root_evt_in = 7'h0;
    logic [15:0] evt_src_id_in = 16'h0;
    logic hdr_capture_in = 1'b0;
    logic [127:0] hdr_in = 128'h0;
    wire [31:0] cfg_rdata_out;
    wire cfg_rvalid_out;
    wire [`FUNC_COUNT-1:0] ch1_enable_out, report_cor_out, report_nonfatal_out, report_fatal_out;
    int fails = 0;
    int checked = 0;
    int seed = 32'h2fe9;
    logic [31:0] exp_q [$];
    logic [31:0] rst_val [26] = '{0: 32'h1, 1: 32'h800000ff, 2: 32'h20000, 3: 32'h1,
        5: 32'h20000, 8: 32'h15010003, 12: 32'h19010001, 15: 32'h62030, 17: 32'h2000,
        default: 32'h0};
    logic [31:0] wr_msk [26] = '{1: 32'he00fe, 4: 32'h870e00fe, 14: 32'h355010,
        15: 32'h355010, 17: 32'h31c1, 23: 32'h7, default: 32'h0};

    pcie_port_vc_aer_regs DUT (.ref_clk_in, .rstn_in, .cfg_func_in, .cfg_addr_in, .cfg_wr_in,
        .cfg_rd_in, .cfg_be_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out, .evt_valid_in,
        .evt_func_in, .unc_evt_in, .cor_evt_in, .root_evt_in, .evt_src_id_in, .hdr_capture_in,
        .hdr_in, .ch1_enable_out, .report_cor_out, .report_nonfatal_out, .report_fatal_out);

    always #50 ref_clk_in = ~ref_clk_in;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a write carries data, a read notes its expected value
    task automatic bus(input logic w, input logic [3:0] f, input logic [11:0] a,
        input logic [31:0] d);
        @(negedge ref_clk_in);
        evt_valid_in = 1'b0;
        cfg_wr_in = w;
        cfg_rd_in = !w;
        cfg_func_in = f;
        cfg_addr_in = a;
        cfg_wdata_in = d;
        if (!w)
            exp_q.push_back(d);
    endtask

    task automatic idle;
        @(negedge ref_clk_in);
        cfg_wr_in = 1'b0;
        cfg_rd_in = 1'b0;
        evt_valid_in = 1'b0;
    endtask

    // m: 0 read reset, 1 write d, 2 read after write d, 3 read zero
    task automatic sweep(input logic [3:0] f, input int m, input logic [31:0] d);
        for (int i = 0; i < 26; i++)
            bus(m == 1, f, 12'h120 + 12'(4 * i), m == 1 ? d : m == 0 ? rst_val[i] :
                m == 3 ? 32'h0 : (rst_val[i] & ~wr_msk[i]) | (d & wr_msk[i]));
    endtask

    task automatic wrap_up;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(negedge ref_clk_in) begin
        if (cfg_rvalid_out === 1'b1) begin
            if (exp_q.size() > 0)
                chk(cfg_rdata_out, exp_q.pop_front());
            else begin
                fails++;
                $display("BAD t=%0t got=%h exp=%h", $time, cfg_rdata_out, 32'h0);
            end
        end
    end

    initial begin
        logic [31:0] r;
        repeat (5) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        rstn_in = 1'b1;
        sweep(4'h2, 0, 32'h0);
        sweep(4'hc, 0, 32'h0);
        for (int k = 0; k < 3; k++) begin
            r = (k == 0) ? 32'hffffffff : (k == 1) ? 32'h0 : $random(seed);
            sweep(4'h3, 1, r);
            sweep(4'h3, 2, r);
        end
        sweep(4'h4, 0, 32'h0);
        sweep(4'hd, 1, 32'hffffffff);
        sweep(4'hd, 3, 32'h0);
        cfg_be_in = 4'h8;
        bus(1, 4'h6, 12'h130, 32'hffffffff);
        idle;
        cfg_be_in = 4'hf;
        idle;
        chk(32'(ch1_enable_out), 32'h10 | {30'h0, r[31], 1'b0});
        bus(0, 4'h6, 12'h130, 32'h87000000);
        bus(1, 4'h5, 12'h17c, 32'h7);
        hdr_in = {$random(seed), $random(seed), $random(seed), $random(seed)};
        @(negedge ref_clk_in);
        cfg_wr_in = 1'b0;
        evt_valid_in = 1'b1;
        evt_func_in = 4'h5;
        unc_evt_in = 32'hffffffff;
        cor_evt_in = 32'hffffffff;
        root_evt_in = 7'h7f;
        evt_src_id_in = 16'h1234;
        hdr_capture_in = 1'b1;
        idle;
        idle;
        chk(32'(report_cor_out), 32'h8);
        chk(32'(report_nonfatal_out), 32'h8);
        chk(32'(report_fatal_out), 32'h8);
        bus(0, 4'h5, 12'h154, 32'h003ff030);
        bus(0, 4'h5, 12'h160, 32'h000031c1);
        bus(0, 4'h5, 12'h180, 32'h0000007f);
        bus(0, 4'h5, 12'h184, 32'h12341234);
        for (int j = 0; j < 4; j++)
            bus(0, 4'h5, 12'h16c + 12'(4 * j), hdr_in[32 * j +: 32]);
        bus(1, 4'h5, 12'h154, 32'h0);
        bus(0, 4'h5, 12'h154, 32'h003ff030);
        bus(1, 4'h5, 12'h154, 32'hffffffff);
        bus(1, 4'h5, 12'h160, 32'hffffffff);
        bus(1, 4'h5, 12'h180, 32'hffffffff);
        bus(0, 4'h5, 12'h154, 32'h000aa020);
        bus(0, 4'h5, 12'h160, 32'h0);
        bus(0, 4'h5, 12'h180, 32'h0);
        idle;
        chk(32'(report_cor_out), 32'h0);
        chk(32'(report_fatal_out), 32'h8);
        for (int i = 0; i < 50 && exp_q.size() > 0; i++)
            @(negedge ref_clk_in);
        if (exp_q.size() > 0)
            fails++;
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
